// ===== hdl/mac_pkt_pkg.sv
// Shared constants and carrier types for the packet FIFO MAC block
package mac_pkt_pkg;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int          ADDR_OCTETS  = 6;
    localparam int          BYTE_W       = 8;
    localparam int          STATION_W    = 48;
    localparam int          END_BIT      = 8;
    localparam int          RX_WORD_W    = 9;
    localparam int          CNT_W        = 16;
    localparam int          RX_DEPTH_DEF = 2048;
    localparam int          TX_DEPTH_DEF = 2048;
    localparam logic [47:0] STATION_RST  = 48'h0000_0000_0000;
    localparam logic [2:0]  LAST_BIT_POS = 3'h7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       ok;
    } rx_beat_t;

    typedef struct packed {
        logic en;
        logic bit_valid;
        logic data;
    } tx_line_t;

    // Octet 0 is the most significant octet of the written address
    function automatic logic [7:0] addr_octet(input logic [47:0] a, input logic [2:0] i);
        return a[(32'(ADDR_OCTETS - 1) - 32'(i)) * 8 +: 8];
    endfunction : addr_octet

endpackage : mac_pkt_pkg

// ===== hdl/mac_pkt_ram.sv
// Simple dual-port memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module mac_pkt_ram #(
    parameter int W = 8,
    parameter int D = 2048
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 we_i,
    input  wire logic [$clog2(D)-1:0] waddr_i,
    input  wire logic [W-1:0]         wdata_i,
    input  wire logic                 re_i,
    input  wire logic [$clog2(D)-1:0] raddr_i,
    output logic      [W-1:0]         rdata_o
);
    logic [W-1:0] mem [D];

    // Array has no reset so it can map onto block memory
    always_ff @(posedge core_clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else if (re_i)
        begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : mac_pkt_ram
`default_nettype wire

// ===== hdl/ethernet_mac_packet_fifo.sv
// Packet FIFO MAC core: station address, receive filter and FIFO, transmit FIFO and serialiser
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - A six-octet station address is written and reads back unchanged.
// - Without promiscuous mode, frames whose destination differs from the station address are dropped.
// - Station address goes on the line first octet first, sixth octet last.
// - Each address octet is serialised least significant bit first.
// - Packet count rises when a frame ends with a good check sequence.
// - Packet count falls only once the last byte, check sequence included, is read.
// - A partly read packet still counts, so nonzero means a packet is there.
// - Host loads a whole packet then requests; sending starts only after the request.
// - Receive FIFO gives frame bytes then check-sequence bytes; host drops the latter.
module ethernet_mac_packet_fifo
    import mac_pkt_pkg::*;
#(
    parameter int RX_DEPTH = RX_DEPTH_DEF,
    parameter int TX_DEPTH = TX_DEPTH_DEF
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 addr_wr_i,
    input  wire logic [STATION_W-1:0] addr_wdata_i,
    output logic      [STATION_W-1:0] addr_rdata_o,
    input  wire logic                 promisc_i,
    input  wire rx_beat_t             rx_beat_i,
    input  wire logic                 rx_rd_i,
    output logic      [BYTE_W-1:0]    rx_rdata_o,
    output logic                      rx_rvalid_o,
    output logic                      rx_rlast_o,
    output logic      [CNT_W-1:0]     rx_pkt_cnt_o,
    input  wire logic                 tx_wr_i,
    input  wire logic [BYTE_W-1:0]    tx_wdata_i,
    output logic                      tx_wready_o,
    input  wire logic                 tx_go_i,
    output logic                      tx_empty_o,
    output var tx_line_t              tx_line_o
);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TAW = $clog2(TX_DEPTH);
    localparam int TW  = TAW + 1;

    // ------------------------------------------------------------
    // Receive side and station address
    // ------------------------------------------------------------
    logic [STATION_W-1:0] addr_r,    addr_nxt;
    logic [RAW-1:0]       rx_wp_r,   rx_wp_nxt;
    logic [RAW-1:0]       rx_base_r, rx_base_nxt;
    logic [RAW-1:0]       rx_rp_r,   rx_rp_nxt;
    logic [2:0]           rx_idx_r,  rx_idx_nxt;
    logic                 rx_drop_r, rx_drop_nxt;
    logic                 rx_rv_r,   rx_rv_nxt;
    logic [CNT_W-1:0]     cnt_r,     cnt_nxt;
    logic                 rx_full;
    logic                 rx_mismatch;
    logic                 rx_drop_now;
    logic                 rx_we;
    logic                 rx_re;
    logic                 rx_commit;
    logic                 rx_dec;
    logic [RX_WORD_W-1:0] rx_q;

    always_comb
    begin
        addr_nxt    = addr_wr_i ? addr_wdata_i : addr_r;
        rx_full     = RAW'(rx_wp_r + 1'b1) == rx_rp_r;
        rx_mismatch = (rx_idx_r < 3'(ADDR_OCTETS)) && !promisc_i &&
                      (rx_beat_i.data != addr_octet(addr_r, rx_idx_r));
        // An overflowing frame is dropped whole rather than stored cut short
        rx_drop_now = rx_drop_r | rx_mismatch | rx_full;
        rx_we       = rx_beat_i.valid & !rx_drop_now;
        rx_commit   = rx_beat_i.valid & rx_beat_i.last & rx_beat_i.ok & !rx_drop_now;
        rx_wp_nxt   = rx_we ? RAW'(rx_wp_r + 1'b1) : rx_wp_r;
        rx_base_nxt = rx_base_r;
        rx_idx_nxt  = rx_idx_r;
        rx_drop_nxt = rx_drop_r;
        if (rx_beat_i.valid)
        begin
            rx_drop_nxt = rx_drop_now;
            if (rx_idx_r < 3'(ADDR_OCTETS))
            begin
                rx_idx_nxt = 3'(rx_idx_r + 1'b1);
            end
            if (rx_beat_i.last)
            begin
                rx_idx_nxt  = 3'h0;
                rx_drop_nxt = 1'b0;
                if (rx_commit)
                begin
                    rx_base_nxt = rx_wp_nxt;
                end
                else
                begin
                    rx_wp_nxt = rx_base_r; // Bad or filtered frame is rolled back
                end
            end
        end
        // Reads stop at the last committed byte, check sequence included
        rx_re     = rx_rd_i && (rx_rp_r != rx_base_r);
        rx_rp_nxt = rx_re ? RAW'(rx_rp_r + 1'b1) : rx_rp_r;
        rx_rv_nxt = rx_re;
        rx_dec    = rx_rv_r & rx_q[END_BIT];
        cnt_nxt   = cnt_r;
        case ({rx_commit, rx_dec})
            2'b10:   cnt_nxt = CNT_W'(cnt_r + 1'b1);
            2'b01:   cnt_nxt = CNT_W'(cnt_r - 1'b1);
            default: cnt_nxt = cnt_r;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_r    <= STATION_RST;
            rx_wp_r   <= '0;
            rx_base_r <= '0;
            rx_rp_r   <= '0;
            rx_idx_r  <= '0;
            rx_drop_r <= 1'b0;
            rx_rv_r   <= 1'b0;
            cnt_r     <= '0;
        end
        else
        begin
            addr_r    <= addr_nxt;
            rx_wp_r   <= rx_wp_nxt;
            rx_base_r <= rx_base_nxt;
            rx_rp_r   <= rx_rp_nxt;
            rx_idx_r  <= rx_idx_nxt;
            rx_drop_r <= rx_drop_nxt;
            rx_rv_r   <= rx_rv_nxt;
            cnt_r     <= cnt_nxt;
        end
    end

    mac_pkt_ram #(.W(RX_WORD_W), .D(RX_DEPTH)) u_rx_ram (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .we_i       (rx_we),
        .waddr_i    (rx_wp_r),
        .wdata_i    ({rx_beat_i.last, rx_beat_i.data}),
        .re_i       (rx_re),
        .raddr_i    (rx_rp_r),
        .rdata_o    (rx_q)
    );

    assign addr_rdata_o = addr_r;
    assign rx_rdata_o   = rx_q[BYTE_W-1:0];
    assign rx_rvalid_o  = rx_rv_r;
    assign rx_rlast_o   = rx_dec;
    assign rx_pkt_cnt_o = cnt_r;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_LATCH, TX_SEND} tx_state_t;
    tx_state_t   tx_st_r,  tx_st_nxt;
    logic [TW-1:0] tx_len_r, tx_len_nxt;
    logic [TW-1:0] tx_idx_r, tx_idx_nxt;
    logic [7:0]  tx_sh_r,  tx_sh_nxt;
    logic [2:0]  tx_bn_r,  tx_bn_nxt;
    logic        tx_ins;
    logic        tx_we;
    logic        tx_re;
    logic [TAW-1:0] tx_raddr;
    logic [7:0]  tx_q;
    always_comb
    begin
        // Station address is inserted as the source field after the destination
        tx_ins      = (tx_idx_r >= TW'(ADDR_OCTETS)) && (tx_idx_r < TW'(2 * ADDR_OCTETS));
        // Loading is only open while idle; a full FIFO refuses further bytes
        tx_wready_o = (tx_st_r == TX_IDLE) && (tx_len_r != TW'(TX_DEPTH));
        tx_we       = tx_wr_i && tx_wready_o;
        tx_raddr    = (tx_idx_r < TW'(ADDR_OCTETS)) ? tx_idx_r[TAW-1:0]
                                                     : TAW'(tx_idx_r - TW'(ADDR_OCTETS));
        tx_re       = (tx_st_r == TX_FETCH) && !tx_ins;
        tx_st_nxt   = tx_st_r;
        tx_len_nxt  = tx_we ? TW'(tx_len_r + 1'b1) : tx_len_r;
        tx_idx_nxt  = tx_idx_r;
        tx_sh_nxt   = tx_sh_r;
        tx_bn_nxt   = tx_bn_r;
        case (tx_st_r)
            TX_IDLE:
            begin
                // A packet shorter than a destination field is never launched
                if (tx_go_i && (tx_len_r >= TW'(ADDR_OCTETS)))
                begin
                    tx_st_nxt  = TX_FETCH;
                    tx_idx_nxt = '0;
                end
            end
            TX_FETCH:
            begin
                tx_st_nxt = TX_LATCH;
            end
            TX_LATCH:
            begin
                tx_sh_nxt = tx_ins ? addr_octet(addr_r, 3'(tx_idx_r - TW'(ADDR_OCTETS))) : tx_q;
                tx_bn_nxt = 3'h0;
                tx_st_nxt = TX_SEND;
            end
            TX_SEND:
            begin
                tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                tx_bn_nxt = 3'(tx_bn_r + 1'b1);
                if (tx_bn_r == LAST_BIT_POS)
                begin
                    tx_idx_nxt = TW'(tx_idx_r + 1'b1);
                    if (tx_idx_r == TW'(tx_len_r + TW'(ADDR_OCTETS - 1)))
                    begin
                        tx_st_nxt  = TX_IDLE;
                        tx_len_nxt = '0;
                    end
                    else
                    begin
                        tx_st_nxt = TX_FETCH;
                    end
                end
            end
            default:
            begin
                tx_st_nxt = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_st_r  <= TX_IDLE;
            tx_len_r <= '0;
            tx_idx_r <= '0;
            tx_sh_r  <= '0;
            tx_bn_r  <= '0;
        end
        else
        begin
            tx_st_r  <= tx_st_nxt;
            tx_len_r <= tx_len_nxt;
            tx_idx_r <= tx_idx_nxt;
            tx_sh_r  <= tx_sh_nxt;
            tx_bn_r  <= tx_bn_nxt;
        end
    end
    mac_pkt_ram #(.W(BYTE_W), .D(TX_DEPTH)) u_tx_ram (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .we_i       (tx_we),
        .waddr_i    (tx_len_r[TAW-1:0]),
        .wdata_i    (tx_wdata_i),
        .re_i       (tx_re),
        .raddr_i    (tx_raddr),
        .rdata_o    (tx_q)
    );

    assign tx_empty_o          = (tx_st_r == TX_IDLE) && (tx_len_r == '0);
    assign tx_line_o.en        = tx_st_r != TX_IDLE;
    assign tx_line_o.bit_valid = tx_st_r == TX_SEND;
    assign tx_line_o.data      = tx_sh_r[0];
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_addr_readback: assert property (@(posedge core_clk_i) disable iff (rst_i)
        addr_wr_i |=> addr_rdata_o == $past(addr_wdata_i))
        else $error("Station address did not read back");
    a_filter_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_beat_i.valid && !promisc_i && rx_idx_r < 3'(ADDR_OCTETS) &&
         rx_beat_i.data != addr_octet(addr_r, rx_idx_r)) |-> !rx_we && !rx_commit)
        else $error("Mismatching destination byte was stored");
    a_promisc_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (promisc_i && rx_beat_i.valid && !rx_full && !rx_drop_r) |-> rx_we)
        else $error("Promiscuous frame byte was not stored");
    a_tx_addr_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (tx_st_r == TX_LATCH && tx_idx_r == TW'(ADDR_OCTETS)) |=> tx_sh_r == addr_octet(addr_r, 3'h0))
        else $error("First address octet not leading");
    a_tx_lsb_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (tx_st_r == TX_SEND && tx_bn_r != LAST_BIT_POS) |=> tx_line_o.data == $past(tx_sh_r[1]))
        else $error("Bits not sent least significant first");
    a_cnt_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_commit && !rx_dec) |=> rx_pkt_cnt_o == CNT_W'($past(rx_pkt_cnt_o) + 1'b1))
        else $error("Packet count did not rise on good frame");
    a_cnt_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_pkt_cnt_o < $past(rx_pkt_cnt_o)) |-> $past(rx_rlast_o))
        else $error("Packet count fell before last byte read");
    a_partial_cnt: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_rvalid_o && !rx_rlast_o) |-> rx_pkt_cnt_o != '0)
        else $error("Partly read packet not counted");
    a_tx_after_go: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(tx_line_o.en) |-> $past(tx_go_i) && $past(tx_len_r) >= TW'(ADDR_OCTETS))
        else $error("Transmit began without a request");
    a_fcs_readout: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rx_re |=> rx_rvalid_o && rx_pkt_cnt_o != '0)
        else $error("Read byte served outside a counted packet");
endmodule : ethernet_mac_packet_fifo
`default_nettype wire

// ===== tb/phy_model.sv
// Line-side transceiver model: frame source and transmit bit collector
`timescale 1ns/100ps
`default_nettype none
module phy_model
    import mac_pkt_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire tx_line_t   tx_line_i,
    output var rx_beat_t    rx_beat_o,
    output logic [7:0]      tx_byte_o,
    output logic            tx_byte_v_o
);
    // ------------------------------------------------------------
    // Receive source
    // ------------------------------------------------------------
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;

    initial rx_beat_o = '0;

    // Idle data is inverted on each call so a stale byte never passes for a fresh one
    task automatic idle();
        rx_beat_o.valid = 1'b0;
        rx_beat_o.last  = 1'b0;
        rx_beat_o.data  = ~rx_beat_o.data;
    endtask : idle

    // Frame bytes then check-sequence bytes, with a gap after every third byte
    task automatic send_frame(input logic [7:0] b[$], input logic ok);
        for (int i = 0; i < b.size(); i++)
        begin
            @(posedge core_clk_i);
            #1;
            rx_beat_o = '{valid: 1'b1, data: b[i], last: (i == b.size() - 1), ok: ok};
            if (i % 3 == 2)
            begin
                @(posedge core_clk_i);
                #1;
                idle();
            end
        end
        @(posedge core_clk_i);
        #1;
        idle();
    endtask : send_frame

    // ------------------------------------------------------------
    // Transmit collector
    // ------------------------------------------------------------
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bit_cnt_r   <= 3'h0;
            tx_byte_v_o <= 1'b0;
        end
        else
        begin
            tx_byte_v_o <= 1'b0;
            if (tx_line_i.bit_valid)
            begin
                shift_r   <= {tx_line_i.data, shift_r[7:1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7)
                begin
                    tx_byte_o   <= {tx_line_i.data, shift_r[7:1]};
                    tx_byte_v_o <= 1'b1;
                end
            end
        end
    end
endmodule : phy_model
`default_nettype wire

// ===== tb/ethernet_mac_packet_fifo_test.sv
// Self-checking bench for the packet FIFO MAC core
`timescale 1ns/100ps
`default_nettype none
module ethernet_mac_packet_fifo_test
    import mac_pkt_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk, rst, addr_wr, promisc, rx_rd, rx_rvalid, rx_rlast;
    logic        tx_wr, tx_wready, tx_go, tx_empty, tx_byte_v;
    logic [47:0] addr_wdata, addr_rdata, sta;
    logic [7:0]  rx_rdata, tx_wdata, tx_byte;
    logic [15:0] rx_pkt_cnt;
    rx_beat_t    rx_beat;
    tx_line_t    tx_line;
    int          fail_count, samples_checked;
    integer      seed = 32'hf19b;
    logic [8:0]  rxq[$];
    logic [7:0]  txq[$], fr[$], buf_q[$];

    ethernet_mac_packet_fifo #(.RX_DEPTH(64), .TX_DEPTH(16)) ethernet_mac_packet_fifo_inst (
        .core_clk_i(core_clk), .rst_i(rst), .addr_wr_i(addr_wr), .addr_wdata_i(addr_wdata),
        .addr_rdata_o(addr_rdata), .promisc_i(promisc), .rx_beat_i(rx_beat), .rx_rd_i(rx_rd),
        .rx_rdata_o(rx_rdata), .rx_rvalid_o(rx_rvalid), .rx_rlast_o(rx_rlast), .rx_pkt_cnt_o(rx_pkt_cnt),
        .tx_wr_i(tx_wr), .tx_wdata_i(tx_wdata), .tx_wready_o(tx_wready), .tx_go_i(tx_go),
        .tx_empty_o(tx_empty), .tx_line_o(tx_line));

    phy_model phy_model_inst (.core_clk_i(core_clk), .rst_i(rst), .tx_line_i(tx_line),
        .rx_beat_o(rx_beat), .tx_byte_o(tx_byte), .tx_byte_v_o(tx_byte_v));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Destination, two payload bytes, four check bytes; notes kept only if stored
    task automatic rx_frame(input logic [47:0] dst, input logic ok, input logic keep);
        fr = {};
        for (int i = 0; i < 12; i++)
            fr.push_back(i < 6 ? dst[47 - 8 * i -: 8] : 8'($random(seed)));
        if (keep)
            foreach (fr[i])
                rxq.push_back({i == 11, fr[i]});
        phy_model_inst.send_frame(fr, ok);
        tick();
    endtask : rx_frame

    task automatic pop(input int n);
        rx_rd = 1'b1;
        repeat (n) tick();
        rx_rd = 1'b0;
        repeat (3) tick();
    endtask : pop

    // ------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
    begin
        if (rx_rvalid === 1'b1)
            check({rx_rlast, rx_rdata}, rxq.pop_front());
        if (tx_byte_v === 1'b1)
            check(tx_byte, txq.pop_front());
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #(100 * 5000);
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {rst, addr_wr, promisc, rx_rd, tx_wr, tx_go} = 6'h20;
        addr_wdata = 48'h0;
        tx_wdata = 8'h0;
        repeat (12) @(posedge core_clk);
        #1;
        rst = 1'b0;
        sta = 48'({$random(seed), $random(seed)});
        addr_wdata = sta;
        addr_wr = 1'b1;
        tick();
        addr_wr = 1'b0;
        check(addr_rdata, sta);
        $display("test address done");
        rx_frame(sta, 1'b1, 1'b1);
        check(rx_pkt_cnt, 1);
        rx_frame(sta ^ 48'h1, 1'b1, 1'b0);
        check(rx_pkt_cnt, 1);
        rx_frame(sta, 1'b0, 1'b0);
        check(rx_pkt_cnt, 1);
        promisc = 1'b1;
        rx_frame(~sta, 1'b1, 1'b1);
        promisc = 1'b0;
        check(rx_pkt_cnt, 2);
        pop(5);
        check(rx_pkt_cnt, 2);
        pop(7);
        check(rx_pkt_cnt, 1);
        pop(13);
        check(rx_pkt_cnt, 0);
        check(rxq.size(), 0);
        $display("test receive done");
        check(tx_empty, 1);
        // Eight bytes keep the packet well inside the transmit FIFO space
        for (int i = 0; i < 8; i++)
        begin
            tx_wdata = 8'($random(seed));
            buf_q.push_back(tx_wdata);
            tx_wr = 1'b1;
            check(tx_wready, 1);
            tick();
        end
        tx_wr = 1'b0;
        check(tx_empty, 0);
        repeat (3)
        begin
            tick();
            check(tx_line.en, 0);
        end
        for (int i = 0; i < 14; i++)
            txq.push_back(i < 6 ? buf_q[i] : i < 12 ? sta[47 - 8 * (i - 6) -: 8] : buf_q[i - 6]);
        tx_go = 1'b1;
        tick();
        tx_go = 1'b0;
        check(tx_line.en, 1);
        check(tx_wready, 0);
        for (int i = 0; i < 400 && tx_empty !== 1'b1; i++)
            tick();
        // Last collected byte is only compared at the following falling edge
        tick();
        check(tx_empty, 1);
        check(txq.size(), 0);
        $display("test transmit done");
        final_report();
    end
endmodule : ethernet_mac_packet_fifo_test
`default_nettype wire
